// ==== core_move_map.svh ====
// constants for the data-move and call instruction decoder
`ifndef CORE_MOVE_MAP_SVH
`define CORE_MOVE_MAP_SVH
// opcode patterns (upper bits of the 16-bit program word; the call pattern is the whole word)
`define LOAD_LITERAL_HI   8'h0E
`define STORE_ACC_HI      7'h37
`define CALL_VIA_ACC_WORD 16'h0014
`define INDEXED_MOVE_HI   9'h1D6
`define SECOND_WORD_HI    4'hF
// field positions
`define BANK_BIT          8
`define OFFSET_WIDTH      7
// extended-mode indexed window limit
`define INDEXED_LIMIT     8'h5F
// return address step
`define RETURN_STEP       21'h000002
// reset values
`define ACC_RESET         8'h00
`define PC_RESET          21'h000000
// indirect-register window and access-bank split in the data space
`define INDIRECT_LO       12'hFDF
`define INDIRECT_HI       12'hFEF
`define ACCESS_SPLIT      8'h60
`define ACCESS_SFR_BANK   4'hF
`endif

// ==== core_move_pkg.sv ====
// types for the data-move and call instruction decoder
package core_move_pkg;
   typedef enum logic [1:0] {phase_decode, phase_read, phase_process, phase_write} phase_e;
   typedef enum logic [1:0] {exec_single, exec_call_nop, exec_move_second} exec_e;
   typedef struct packed {
      logic        write;
      logic [11:0] addr;
      logic [7:0]  data;
   } data_write_s;
endpackage : core_move_pkg

// ==== move_call_decoder.sv ====
// decode and execute of literal load, store, call-through-accumulator and indexed move
//
// Functional notes
// - literal load sets accumulator, flags unchanged
// - store accumulator into banked file register
// - bank bit zero access bank, else bank_select
// - extended mode, low address uses pointer offset
// - call pushes program counter plus two
// - call loads counter from accumulator and latches
// - call takes two cycles, second no-op
// - move source is pointer_two plus offset
// - move destination is twelve-bit absolute address
// - indirect source reads zero, zero written
`include "core_move_map.svh"
module move_call_decoder
   import core_move_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic [15:0] prog_word,
   input  wire logic        extended_en,
   input  wire logic [3:0]  bank_select_reg,
   input  wire logic [11:0] pointer_two,
   input  wire logic [7:0]  counter_latch_high,
   input  wire logic [4:0]  counter_latch_upper,
   input  wire logic [7:0]  data_read,
   output logic [11:0]      data_read_addr,
   output data_write_s      data_write,
   output logic [7:0]       accumulator_reg,
   output logic [20:0]      prog_counter,
   output logic             push_strobe,
   output logic [20:0]      stack_top,
   output logic             fetch_strobe,
   output phase_e           phase
);

   // ***************************************************
   // reset release
   // ***************************************************
   logic rst_meta;
   logic rst_sync_n;

   // two-stage release keeps the async reset edge off the core logic
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta   <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta   <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   // ***************************************************
   // phase sequencer
   // ***************************************************
   phase_e next_phase;

   // one instruction cycle is four core clocks
   always_comb begin
      unique case (phase)
         phase_decode:  next_phase = phase_read;
         phase_read:    next_phase = phase_process;
         phase_process: next_phase = phase_write;
         phase_write:   next_phase = phase_decode;
      endcase
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         phase <= phase_decode;
      end else begin
         phase <= next_phase;
      end
   end

   // ***************************************************
   // decode
   // ***************************************************
   logic        is_load;
   logic        is_store;
   logic        is_call;
   logic        is_move;
   logic [7:0]  file_field;
   logic [11:0] store_addr;
   logic [11:0] move_source;

   assign is_load    = (prog_word[15:8] == `LOAD_LITERAL_HI);
   assign is_store   = (prog_word[15:9] == `STORE_ACC_HI);
   assign is_call    = (prog_word == `CALL_VIA_ACC_WORD);
   assign is_move    = (prog_word[15:7] == `INDEXED_MOVE_HI);
   assign file_field = prog_word[7:0];

   // banked address of store; access bank splits low RAM and high SFRs
   always_comb begin
      if (prog_word[`BANK_BIT]) begin
         store_addr = {bank_select_reg, file_field};
      end else if (extended_en && (file_field <= `INDEXED_LIMIT)) begin
         store_addr = pointer_two + {4'h0, file_field};
      end else if (file_field < `ACCESS_SPLIT) begin
         store_addr = {4'h0, file_field};
      end else begin
         store_addr = {`ACCESS_SFR_BANK, file_field};
      end
   end

   // unsigned 7-bit offset added to the pointer, wraps in 4 KB space
   assign move_source = pointer_two + {5'h00, prog_word[`OFFSET_WIDTH-1:0]};

   // ***************************************************
   // execute state
   // ***************************************************
   exec_e       exec;
   exec_e       next_exec;
   logic [11:0] held_source;
   logic [11:0] next_held_source;
   logic [7:0]  next_acc;
   logic [20:0] next_pc;
   logic [20:0] next_stack_top;
   logic        next_push;
   logic        next_fetch;
   logic [11:0] next_read_addr;
   data_write_s next_write;
   logic [7:0]  move_data;

   // indirect registers read as zero instead of an indirect access
   assign move_data = ((held_source >= `INDIRECT_LO) && (held_source <= `INDIRECT_HI)) ?
                      8'h00 : data_read;

   // all actions except the move source read address commit in the write-back phase
   always_comb begin
      next_exec        = exec;
      next_held_source = held_source;
      next_acc         = accumulator_reg;
      next_pc          = prog_counter;
      next_stack_top   = stack_top;
      next_push        = 1'b0;
      next_fetch       = 1'b0;
      next_read_addr   = data_read_addr;
      next_write       = '0;
      if (phase == phase_read && exec == exec_single && is_move) begin
         next_read_addr = move_source; // source read ahead of the second word
      end
      if (phase == phase_write) begin
         next_fetch = 1'b1;
         unique case (exec)
            exec_single: begin
               next_pc = prog_counter + `RETURN_STEP;
               if (is_load) begin
                  next_acc = file_field;
               end else if (is_store) begin
                  next_write = '{write: 1'b1, addr: store_addr, data: accumulator_reg};
               end else if (is_call) begin
                  next_stack_top = prog_counter + `RETURN_STEP;
                  next_push      = 1'b1;
                  next_pc        = {counter_latch_upper, counter_latch_high, accumulator_reg};
                  next_exec      = exec_call_nop;
               end else if (is_move) begin
                  next_held_source = move_source;
                  next_exec        = exec_move_second;
               end
            end
            exec_call_nop: begin
               next_pc   = prog_counter + `RETURN_STEP; // target fetched, no operation
               next_exec = exec_single;
            end
            exec_move_second: begin
               next_pc    = prog_counter + `RETURN_STEP;
               next_write = '{write: 1'b1, addr: prog_word[11:0], data: move_data};
               next_exec  = exec_single;
            end
            default: next_exec = exec_single;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         exec            <= exec_single;
         held_source     <= 12'h000;
         accumulator_reg <= `ACC_RESET;
         prog_counter    <= `PC_RESET;
         stack_top       <= `PC_RESET;
         push_strobe     <= 1'b0;
         fetch_strobe    <= 1'b0;
         data_read_addr  <= 12'h000;
         data_write      <= '0;
      end else begin
         exec            <= next_exec;
         held_source     <= next_held_source;
         accumulator_reg <= next_acc;
         prog_counter    <= next_pc;
         stack_top       <= next_stack_top;
         push_strobe     <= next_push;
         fetch_strobe    <= next_fetch;
         data_read_addr  <= next_read_addr;
         data_write      <= next_write;
      end
   end

endmodule : move_call_decoder

// ==== move_call_props.sv ====
// checker for the move and call decoder ports
module move_call_props
   import core_move_pkg::*;
(
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic [15:0] prog_word,
   input wire logic [11:0] pointer_two,
   input wire logic [7:0]  counter_latch_high,
   input wire logic [4:0]  counter_latch_upper,
   input wire logic [11:0] data_read_addr,
   input data_write_s      data_write,
   input wire logic [7:0]  accumulator_reg,
   input wire logic [20:0] prog_counter,
   input wire logic        push_strobe,
   input wire logic [20:0] stack_top,
   input wire logic        fetch_strobe,
   input phase_e           phase
);
   // ****************************
   // instruction result checks
   // ****************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // results land on the edge that leaves the write phase
   a_load_sets_acc: assert property ((phase == phase_write && prog_word[15:8] == 8'h0E) |=>
      accumulator_reg == $past(prog_word[7:0])) else $error("literal load result wrong");
   a_store_acc_data: assert property ((phase == phase_write && prog_word[15:9] == 7'h37) |=>
      data_write.write && data_write.data == $past(accumulator_reg)) else $error("store write wrong");
   a_call_push_ret: assert property ((phase == phase_write && prog_word == 16'h0014) |=>
      push_strobe && stack_top == $past(prog_counter) + 21'h000002) else $error("call push wrong");
   a_call_target: assert property ((phase == phase_write && prog_word == 16'h0014) |=>
      prog_counter == {$past(counter_latch_upper), $past(counter_latch_high), $past(accumulator_reg)})
      else $error("call target wrong");
   // source address is ready before the first word retires
   a_move_source: assert property ((phase == phase_write && prog_word[15:7] == 9'h1D6) |->
      data_read_addr == pointer_two + 12'(prog_word[6:0])) else $error("move source wrong");
   a_fetch_gap: assert property (fetch_strobe |=> !fetch_strobe [*3] ##1 fetch_strobe)
      else $error("fetch spacing wrong");
   a_phase_wrap: assert property (phase == phase_write |=> phase == phase_decode && fetch_strobe)
      else $error("phase wrap wrong");
   a_push_single: assert property (push_strobe |=> !push_strobe)
      else $error("push not a pulse");
endmodule : move_call_props
bind move_call_decoder move_call_props u_props (.clock, .rst_n, .prog_word, .pointer_two, .counter_latch_high,
   .counter_latch_upper, .data_read_addr, .data_write, .accumulator_reg, .prog_counter, .push_strobe,
   .stack_top, .fetch_strobe, .phase);

// ==== move_call_decoder_tb_top.sv ====
// testbench for the move and call decoder
module move_call_decoder_tb_top
   import core_move_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock = 0, rst_n = 0, extended_en = 0, push_strobe, fetch_strobe;
   logic [15:0] prog_word = 16'h0000;
   logic [3:0]  bank_select_reg = 4'h3;
   logic [11:0] pointer_two = 12'h100, data_read_addr;
   logic [7:0]  counter_latch_high = 8'h10, data_read = 8'h33, accumulator_reg;
   logic [4:0]  counter_latch_upper = 5'h01;
   logic [20:0] prog_counter, stack_top, pc0;
   data_write_s data_write;
   phase_e      phase;
   int          errors = 0, tests_run = 0;
   move_call_decoder dut (.clock, .rst_n, .prog_word, .extended_en, .bank_select_reg, .pointer_two,
      .counter_latch_high, .counter_latch_upper, .data_read, .data_read_addr, .data_write,
      .accumulator_reg, .prog_counter, .push_strobe, .stack_top, .fetch_strobe, .phase);
   // ****************************
   // helpers
   // ****************************
   initial forever #2 clock = ~clock;
   task chk(string n, logic [20:0] e, logic [20:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask : chk
   // word held for a whole cycle; pc0 keeps its address
   task ins(logic [15:0] w);
      @(posedge clock) prog_word <= w;
      repeat (3) @(posedge clock);
      #1 pc0 = prog_counter;
   endtask : ins
   task nxt;
      @(posedge clock) prog_word <= 16'h0000;
      #1;
   endtask : nxt
   task pad;
      repeat (3) @(posedge clock);
      #1;
   endtask : pad
   task store(logic [15:0] w, logic [11:0] a);
      ins(w);
      nxt;
      chk("store wr", 21'h1, 21'(data_write.write));
      chk("store addr", 21'(a), 21'(data_write.addr));
      chk("store data", 21'h5A, 21'(data_write.data));
      pad;
   endtask : store
   task move(logic [11:0] p, logic [15:0] w1, logic [15:0] w2, logic [11:0] s, logic [7:0] d);
      pointer_two <= p;
      ins(w1);
      ins(w2);
      nxt;
      chk("move src", 21'(s), 21'(data_read_addr));
      chk("move dst", {9'h000, w2[11:0]}, 21'(data_write.addr));
      chk("move data", 21'(d), 21'(data_write.data) | {20'h00000, ~data_write.write});
      pad;
   endtask : move
   // ****************************
   // scenarios
   // ****************************
   task t_load;
      ins(16'h0E5A);
      nxt;
      chk("acc", 21'h5A, 21'(accumulator_reg));
      chk("pc step", pc0 + 21'h2, prog_counter);
      chk("fetch", 21'h1, 21'(fetch_strobe));
      pad;
   endtask : t_load
   task t_store;
      store(16'h6E30, 12'h030);
      store(16'h6E80, 12'hF80);
      store(16'h6F45, 12'h345);
      extended_en <= 1'b1;
      store(16'h6E5F, 12'h15F);
      store(16'h6E60, 12'hF60);
      extended_en <= 1'b0;
   endtask : t_store
   task t_call;
      ins(16'h0014);
      nxt;
      chk("push", 21'h1, 21'(push_strobe));
      chk("return", pc0 + 21'h2, stack_top);
      chk("target", 21'h01105A, prog_counter);
      pad;
      nxt;
      chk("nop pc", 21'h01105C, prog_counter);
      chk("no push", 21'h0, 21'(push_strobe));
      pad;
   endtask : t_call
   task t_move;
      move(12'h100, 16'hEB05, 16'hFABC, 12'h105, 8'h33);
      // destinations stay clear of the counter and stack-top registers
      move(12'hF80, 16'hEB7F, 16'hF000, 12'hFFF, 8'h33);
      move(12'hFE0, 16'hEB0F, 16'hFEFF, 12'hFEF, 8'h00);
   endtask : t_move
   task end_of_test;
      if (errors == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   // whole run needs well under a microsecond and a half
   initial begin
      #6000;
      errors++;
      end_of_test;
   end
   initial begin
      repeat (5) @(posedge clock);
      rst_n <= 1;
      do begin
         @(posedge clock);
         #1;
      end while (phase !== phase_write);
      t_load;
      t_store;
      t_call;
      t_move;
      end_of_test;
   end
endmodule : move_call_decoder_tb_top
